// [adtp_regs.svh]
/*
 * register indices, field positions, reset values and timing counts
 * of the converter and touch panel control block.
 * assumes a 25 MHz system clock and a word-per-register bus map.
 */
// Operation
// - high result byte holds bits 11..4
// - low result upper nibble holds bits 3..0
// - enable bit starts converter; bits 1..0 pick channel
// - clock select: clear slow, set fast
// - touch bit 6: wake only or wake+reset
// - touch bit 7 enables touch-detect wake-up
// - four write-only touch switch controls, set closes
// - one-time mode sets done flag at finish
`ifndef ADTP_REGS_SVH
`define ADTP_REGS_SVH

// register indices, byte address is four times the index
`define ADTP_IDX_RES_HI 16'h103a
`define ADTP_IDX_RES_LO 16'h103b
`define ADTP_IDX_CTL1 16'h103c
`define ADTP_IDX_CTL2 16'h103d
`define ADTP_IDX_STAT 16'h103e

// primary control fields
`define ADTP_C1_IE 6
`define ADTP_C1_LOOP 5
`define ADTP_C1_TOUCH 4
`define ADTP_C1_EN 3
`define ADTP_C1_FAST 2

// touch control fields
`define ADTP_C2_WAKE 7
`define ADTP_C2_WRST 6

// status fields
`define ADTP_ST_DONE 1
`define ADTP_ST_TOUCH 0

// reset values
`define ADTP_RST_BYTE 8'h00
`define ADTP_RST_RES 12'h000

// conversion clock
`define ADTP_SYS_HZ 25000000
`define ADTP_SLOW_HZ 230000
`define ADTP_FAST_HZ 460000
`define ADTP_SLOW_HALF (`ADTP_SYS_HZ / (2 * `ADTP_SLOW_HZ))
`define ADTP_FAST_HALF (`ADTP_SYS_HZ / (2 * `ADTP_FAST_HZ))

`endif

// [adtp_pkg.sv]
/*
 * types of the converter and touch panel control block.
 * assumes adtp_regs.svh carries the numeric constants.
 */
package adtp_pkg;

    typedef enum logic [1:0] {
        ADTP_IDLE = 2'b00,
        ADTP_START = 2'b01,
        ADTP_WAIT = 2'b10
    } adtp_state_t;

    typedef logic [7:0] adtp_byte_t;
    typedef logic [11:0] adtp_res_t;

endpackage : adtp_pkg

// [adtp_ctrl.sv]
/*
 * converter and touch panel control: ahb-lite register slave,
 * conversion sequencer, conversion clock divider, touch switches
 * and touch-detect wake-up.
 * assumes the converter core answers a start pulse with one done
 * pulse carrying the 12-bit result; pins are synchronous to clk_i.
 */
`include "adtp_regs.svh"

module adtp_ctrl
    import adtp_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // converter core
    output logic conv_en_o,
    output logic conv_start_o,
    output logic [1:0] conv_chan_o,
    output logic conv_touch_mode_o,
    output logic conv_clk_o,
    input wire logic conv_done_i,
    input wire logic [11:0] conv_data_i,
    // touch panel
    output logic [3:0] touch_sw_o,
    input wire logic touch_detect_i,
    output logic touch_detect_wake_o,
    output logic touch_wake_reset_o,
    // interrupt request
    output logic irq_o
);

    // address decode helper
    function automatic logic adtp_hit(input logic [31:0] a, input logic [15:0] idx);
        adtp_hit = (a == {14'h0000, idx, 2'b00});
    endfunction : adtp_hit

    // bus state
    logic wr_pend_q;
    logic wr_pend_d;
    logic [31:0] wr_addr_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic hready_q;

    // control state
    adtp_byte_t ctl1_q;
    adtp_byte_t ctl2_q;
    adtp_res_t res_q;
    logic done_q;
    logic done_d;
    logic touch_q;
    logic irq_q;
    logic start_q;
    adtp_state_t state_q;
    adtp_state_t state_d;

    // conversion clock divider
    logic [7:0] div_q;
    logic cclk_q;

    // address phase decode
    wire take = hsel_i & htrans_i[1] & hready_i;
    wire take_rd = take & ~hwrite_i;
    wire take_wr = take & hwrite_i;

    // data phase write decode
    wire wr_ctl1 = wr_pend_q & adtp_hit(wr_addr_q, `ADTP_IDX_CTL1);
    wire wr_ctl2 = wr_pend_q & adtp_hit(wr_addr_q, `ADTP_IDX_CTL2);
    wire wr_stat = wr_pend_q & adtp_hit(wr_addr_q, `ADTP_IDX_STAT);
    wire [7:0] wbyte = hwdata_i[7:0];

    // control fields
    wire en_bit = ctl1_q[`ADTP_C1_EN];
    wire loop_bit = ctl1_q[`ADTP_C1_LOOP];
    wire ie_bit = ctl1_q[`ADTP_C1_IE];
    wire fast_bit = ctl1_q[`ADTP_C1_FAST];
    wire wake_bit = ctl2_q[`ADTP_C2_WAKE];
    wire wrst_bit = ctl2_q[`ADTP_C2_WRST];

    // start request: enable bit written high
    wire go_req = wr_ctl1 & wbyte[`ADTP_C1_EN];
    wire conv_end = (state_q == ADTP_WAIT) & conv_done_i;

    // read data of each register except primary control, which reads as zero
    wire [7:0] rd_hi = res_q[11:4];
    wire [7:0] rd_lo = {res_q[3:0], 4'h0};
    wire [7:0] rd_c2 = {ctl2_q[7:6], 6'h00};
    wire [7:0] rd_st = {6'h00, done_q, touch_q};

    // read mux
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (adtp_hit(haddr_i, `ADTP_IDX_RES_HI)) begin
            rdata_d = {24'h000000, rd_hi};
        end
        if (adtp_hit(haddr_i, `ADTP_IDX_RES_LO)) begin
            rdata_d = {24'h000000, rd_lo};
        end
        if (adtp_hit(haddr_i, `ADTP_IDX_CTL2)) begin
            rdata_d = {24'h000000, rd_c2};
        end
        if (adtp_hit(haddr_i, `ADTP_IDX_STAT)) begin
            rdata_d = {24'h000000, rd_st};
        end
    end

    // done flag next value
    always_comb begin
        done_d = done_q;
        if (wr_stat & ~wbyte[`ADTP_ST_DONE]) begin
            done_d = 1'b0;
        end
        if (conv_end & ~loop_bit) begin
            done_d = 1'b1;
        end
    end

    // sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ADTP_IDLE: begin
                if (go_req) begin
                    state_d = ADTP_START;
                end
            end
            ADTP_START: begin
                state_d = ADTP_WAIT;
            end
            ADTP_WAIT: begin
                if (~en_bit) begin
                    state_d = ADTP_IDLE;
                end else if (conv_done_i) begin
                    state_d = loop_bit ? ADTP_START : ADTP_IDLE;
                end
            end
            default: begin
                state_d = ADTP_IDLE;
            end
        endcase
    end

    // pending write capture
    always_comb begin
        wr_pend_d = wr_pend_q;
        if (hready_q) begin
            wr_pend_d = take_wr;
        end
    end

    // write address capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 32'h0000_0000;
        end else if (ce_i) begin
            wr_pend_q <= wr_pend_d;
            if (take_wr) begin
                wr_addr_q <= haddr_i;
            end
        end
    end

    // read data loaded at address phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (ce_i & take_rd) begin
            rdata_q <= rdata_d;
        end
    end

    // zero wait states
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hready_q <= 1'b1;
        end else if (ce_i) begin
            hready_q <= 1'b1;
        end
    end

    // control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl1_q <= `ADTP_RST_BYTE;
            ctl2_q <= `ADTP_RST_BYTE;
        end else if (ce_i) begin
            if (wr_ctl1) begin
                ctl1_q <= {1'b0, wbyte[6:0]};
            end
            if (wr_ctl2) begin
                ctl2_q <= {wbyte[7:6], 2'b00, wbyte[3:0]};
            end
        end
    end

    // sequencer state and start pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ADTP_IDLE;
            start_q <= 1'b0;
        end else if (ce_i) begin
            state_q <= state_d;
            start_q <= (state_q == ADTP_START) & en_bit;
        end
    end

    // conversion result
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_q <= `ADTP_RST_RES;
        end else if (ce_i & conv_end) begin
            res_q <= conv_data_i;
        end
    end

    // done flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
        end else if (ce_i) begin
            done_q <= done_d;
        end
    end

    // interrupt request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else if (ce_i) begin
            irq_q <= ie_bit & done_d & ~done_q;
        end
    end

    // touch detect input register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            touch_q <= 1'b0;
        end else if (ce_i) begin
            touch_q <= touch_detect_i;
        end
    end

    // conversion clock divider
    wire [7:0] half_cnt = fast_bit ? 8'(`ADTP_FAST_HALF) : 8'(`ADTP_SLOW_HALF);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= 8'h00;
            cclk_q <= 1'b0;
        end else if (ce_i) begin
            if (~en_bit) begin
                div_q <= 8'h00;
                cclk_q <= 1'b0;
            end else if (div_q >= half_cnt - 8'h01) begin
                div_q <= 8'h00;
                cclk_q <= ~cclk_q;
            end else begin
                div_q <= div_q + 8'h01;
            end
        end
    end

    // converter side outputs
    logic en_out_q;
    logic [1:0] chan_q;
    logic mode_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_out_q <= 1'b0;
            chan_q <= 2'b00;
            mode_q <= 1'b0;
        end else if (ce_i) begin
            en_out_q <= en_bit;
            chan_q <= ctl1_q[1:0];
            mode_q <= ctl1_q[`ADTP_C1_TOUCH];
        end
    end

    // touch side outputs
    logic [3:0] sw_q;
    logic wake_q;
    logic wrst_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_q <= 4'h0;
            wake_q <= 1'b0;
            wrst_q <= 1'b0;
        end else if (ce_i) begin
            sw_q <= ctl2_q[3:0];
            wake_q <= wake_bit & touch_q;
            wrst_q <= wake_bit & wrst_bit & touch_q;
        end
    end

    assign hrdata_o = rdata_q;
    assign hreadyout_o = hready_q;
    assign hresp_o = 1'b0;
    assign conv_en_o = en_out_q;
    assign conv_start_o = start_q;
    assign conv_chan_o = chan_q;
    assign conv_touch_mode_o = mode_q;
    assign conv_clk_o = cclk_q;
    assign touch_sw_o = sw_q;
    assign touch_detect_wake_o = wake_q;
    assign touch_wake_reset_o = wrst_q;
    assign irq_o = irq_q;

endmodule : adtp_ctrl

// [adtp_chk.sv]
/* port assertions for the control block.
   assumes a bind from the bench top and one clock domain. */
module adtp_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // watched ports
    input wire logic conv_en_o,
    input wire logic conv_start_o,
    input wire logic conv_clk_o,
    input wire logic conv_done_i,
    input wire logic touch_detect_i,
    input wire logic touch_detect_wake_o,
    input wire logic touch_wake_reset_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_done_back;
        $past(conv_done_i) || $past(conv_done_i, 2) || $past(conv_done_i, 3);
    endsequence
    property p_start_en; conv_start_o |-> conv_en_o; endproperty
    property p_start_pulse; conv_start_o |=> !conv_start_o; endproperty
    property p_irq_cause; irq_o |-> s_done_back; endproperty
    property p_irq_pulse; irq_o |=> !irq_o; endproperty
    property p_clk_half;
        disable iff (rst_i || !conv_en_o) $changed(conv_clk_o) |=> $stable(conv_clk_o) [*8];
    endproperty
    property p_clk_off; !conv_en_o && !$past(conv_en_o) |-> !conv_clk_o; endproperty
    property p_wake;
        touch_detect_wake_o |-> $past(touch_detect_i) || $past(touch_detect_i, 2);
    endproperty
    property p_wake_rst; touch_wake_reset_o |-> touch_detect_wake_o; endproperty
    a_start_en: assert property (p_start_en) else $error("start while off");
    a_start_pulse: assert property (p_start_pulse) else $error("long start");
    a_irq_cause: assert property (p_irq_cause) else $error("irq without done");
    a_irq_pulse: assert property (p_irq_pulse) else $error("long irq");
    a_clk_half: assert property (p_clk_half) else $error("short half period");
    a_clk_off: assert property (p_clk_off) else $error("clock while off");
    a_wake: assert property (p_wake) else $error("wake without touch");
    a_wake_rst: assert property (p_wake_rst) else $error("reset without wake");
endmodule : adtp_chk

// [adtp_core_model.sv]
/* converter core stand-in: one done pulse and a result per start.
   assumes start pulses on clk_i; result line floats between dones. */
module adtp_core_model (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic en_i,
    input wire logic [7:0] lat_i,
    input wire logic [11:0] sample_i,
    output logic done_o,
    output logic [11:0] data_o
);
    logic [7:0] cnt_q = 8'h00;
    logic busy_q = 1'b0;
    logic [11:0] last_q = 12'h000;
    initial done_o = 1'b0;
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (!en_i) begin
            busy_q <= 1'b0;
        end else if (start_i) begin
            busy_q <= 1'b1;
            cnt_q <= lat_i;
        end else if (busy_q && cnt_q == 8'h00) begin
            busy_q <= 1'b0;
            done_o <= 1'b1;
            last_q <= sample_i;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
    // floating line shows the inverse
    assign data_o = done_o ? last_q : ~last_q;
endmodule : adtp_core_model

// [adtp_ctrl_test.sv]
/* self-checking bench for the control block over ahb-lite.
   assumes the core model and checker files are compiled first. */
`include "adtp_regs.svh"
module adtp_ctrl_test import adtp_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] A_HI = 32'({`ADTP_IDX_RES_HI, 2'b00});
    localparam logic [31:0] A_LO = 32'({`ADTP_IDX_RES_LO, 2'b00});
    localparam logic [31:0] A_C1 = 32'({`ADTP_IDX_CTL1, 2'b00});
    localparam logic [31:0] A_C2 = 32'({`ADTP_IDX_CTL2, 2'b00});
    localparam logic [31:0] A_ST = 32'({`ADTP_IDX_STAT, 2'b00});
    logic clk_i = 1'b0, rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0, touch_detect_i = 1'b0;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic [7:0] lat = 8'h05;
    logic [11:0] sample = 12'h000;
    wire logic [31:0] hrdata_o;
    wire logic [11:0] conv_data_i;
    wire logic [3:0] touch_sw_o;
    wire logic [1:0] conv_chan_o;
    wire logic hreadyout_o, conv_en_o, conv_start_o, conv_touch_mode_o, conv_clk_o, conv_done_i;
    wire logic touch_detect_wake_o, touch_wake_reset_o, irq_o, hresp_o;
    int err_count = 0, checks_done = 0, irq_n = 0;
    adtp_ctrl dut (.clk_i, .rst_i, .ce_i(1'b1), .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
        .conv_en_o, .conv_start_o, .conv_chan_o, .conv_touch_mode_o, .conv_clk_o, .conv_done_i,
        .conv_data_i, .touch_sw_o, .touch_detect_i, .touch_detect_wake_o, .touch_wake_reset_o,
        .irq_o);
    adtp_core_model u_core (.clk_i, .start_i(conv_start_o), .en_i(conv_en_o), .lat_i(lat),
        .sample_i(sample), .done_o(conv_done_i), .data_o(conv_data_i));
    initial forever #20 clk_i = ~clk_i;
    always @(posedge clk_i) if (irq_o === 1'b1) irq_n++;
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    task automatic chk(input adtp_byte_t got, input adtp_byte_t exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic edges(input int k, input logic lvl);
        int n;
        for (n = 0; n < 900 && k > 0; n++) begin
            @(posedge clk_i);
            if ((lvl ? conv_done_i : hreadyout_o) === 1'b1) k--;
        end
        if (k > 0) begin
            err_count++;
            $display("Error at %0t: wait timed out", $time);
            results();
        end
    endtask : edges
    task automatic bus(input logic w, input logic [31:0] a, input adtp_byte_t d,
        output adtp_byte_t q);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= w;
        edges(1, 1'b0);
        htrans_i <= 2'h0;
        hsel_i <= 1'b0;
        hwdata_i <= {24'h0, d};
        edges(1, 1'b0);
        q = hrdata_o[7:0];
    endtask : bus
    task automatic wr(input logic [31:0] a, input adtp_byte_t d);
        adtp_byte_t q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [31:0] a, input adtp_byte_t e);
        adtp_byte_t q;
        bus(1'b0, a, 8'h00, q);
        chk(q, e);
        chk({7'h0, hresp_o}, 8'h00);
    endtask : rd
    task automatic t_reset();
        logic [31:0] a[6] = '{A_HI, A_LO, A_C1, A_C2, A_ST, 32'h00004100};
        foreach (a[i]) rd(a[i], 8'h00);
        wr(A_HI, 8'hff);
        rd(A_HI, 8'h00);
        $display("reset test done");
    endtask : t_reset
    task automatic t_single();
        adtp_byte_t q;
        int c, n, m;
        for (c = 0; c < 4; c++) begin
            sample <= 12'h9a5 + 12'(c);
            lat <= c[0] ? 8'h28 : 8'h05;
            m = irq_n;
            wr(A_C1, {5'b01001, c[0], 2'(c)});
            q = 8'h00;
            for (n = 0; n < 60 && q[1] !== 1'b1; n++) bus(1'b0, A_ST, 8'h00, q);
            chk(q, 8'h02);
            chk({6'h00, conv_chan_o}, 8'(c));
            rd(A_HI, 8'h9a);
            rd(A_LO, {4'(5 + c), 4'h0});
            rd(A_C1, 8'h00);
            chk(8'(irq_n - m), 8'h01);
            wr(A_ST, 8'h00);
            rd(A_ST, 8'h00);
            wr(A_C1, 8'h00);
        end
        $display("single test done");
    endtask : t_single
    task automatic t_loop();
        int m;
        sample <= 12'h123;
        m = irq_n;
        wr(A_C1, 8'h68);
        edges(2, 1'b1);
        sample <= 12'h456;
        edges(2, 1'b1);
        rd(A_HI, 8'h45);
        rd(A_LO, 8'h60);
        rd(A_ST, 8'h00);
        chk(8'(irq_n - m), 8'h00);
        wr(A_C1, 8'h00);
        $display("loop test done");
    endtask : t_loop
    task automatic t_touch();
        int i;
        for (i = 0; i < 4; i++) begin
            wr(A_C2, 8'h01 << i);
            edges(2, 1'b0);
            chk({4'h0, touch_sw_o}, 8'h01 << i);
        end
        wr(A_C1, 8'h10);
        edges(2, 1'b0);
        chk({7'h0, conv_touch_mode_o}, 8'h01);
        touch_detect_i <= 1'b1;
        wr(A_C2, 8'hc0);
        edges(2, 1'b0);
        chk({6'h0, touch_detect_wake_o, touch_wake_reset_o}, 8'h03);
        chk({4'h0, touch_sw_o}, 8'h00);
        rd(A_C2, 8'hc0);
        rd(A_ST, 8'h01);
        wr(A_C2, 8'h80);
        edges(2, 1'b0);
        chk({6'h0, touch_detect_wake_o, touch_wake_reset_o}, 8'h02);
        wr(A_C1, 8'h00);
        wr(A_C2, 8'h40);
        edges(2, 1'b0);
        chk({6'h0, touch_detect_wake_o, touch_wake_reset_o}, 8'h00);
        $display("touch test done");
    endtask : t_touch
    task automatic half(output int n);
        logic last;
        int t;
        last = conv_clk_o;
        n = 0;
        for (t = 0; t < 200 && conv_clk_o === last; t++) begin
            @(posedge clk_i);
            n++;
        end
        if (conv_clk_o === last) begin
            err_count++;
            $display("Error at %0t: conversion clock stuck", $time);
            results();
        end
    endtask : half
    task automatic t_clock();
        int n;
        wr(A_C1, 8'h28);
        half(n);
        half(n);
        chk(8'(n), 8'(`ADTP_SLOW_HALF));
        wr(A_C1, 8'h2c);
        half(n);
        half(n);
        chk(8'(n), 8'(`ADTP_FAST_HALF));
        wr(A_C1, 8'h00);
        edges(2, 1'b0);
        chk({7'h0, conv_clk_o}, 8'h00);
        $display("clock test done");
    endtask : t_clock
    task automatic t_rerun();
        wr(A_C2, 8'hc5);
        rst_i <= 1'b1;
        edges(2, 1'b0);
        rst_i <= 1'b0;
        rd(A_C2, 8'h00);
        chk({4'h0, touch_sw_o}, 8'h00);
        chk({6'h0, touch_detect_wake_o, touch_wake_reset_o}, 8'h00);
        $display("reset rerun test done");
    endtask : t_rerun
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_single();
        t_loop();
        t_clock();
        t_touch();
        t_rerun();
        results();
    end
endmodule : adtp_ctrl_test
bind adtp_ctrl adtp_chk u_chk (.clk_i, .rst_i, .conv_en_o, .conv_start_o, .conv_clk_o,
    .conv_done_i, .touch_detect_i, .touch_detect_wake_o, .touch_wake_reset_o, .irq_o);
